// [hw/eswp_pkg.sv]
package eswp_pkg;
  // Command bytes
  localparam logic [7:0] CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
  localparam logic [7:0] CMD_STAT_RD = 8'h05;
  localparam logic [7:0] CMD_STAT_WR = 8'h01;
  localparam logic [7:0] CMD_ARR_WR = 8'h02;
  localparam logic [7:0] CMD_ARR_RD = 8'h03;
  // Status bit positions
  localparam int BIT_PIN_EN = 7;
  localparam int BIT_GUARD_HI = 3;
  localparam int BIT_GUARD_LO = 2;
  localparam int BIT_LATCH = 1;
  localparam int BIT_BUSY = 0;
  // Bit counts of a frame
  localparam logic [5:0] CNT_BYTE = 6'h08;
  localparam logic [5:0] CNT_STAT_WR = 6'h10;
  localparam logic [5:0] CNT_ARR_HDR = 6'h18;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Guard region starts
  localparam logic [12:0] GUARD_QTR = 13'h1800;
  localparam logic [12:0] GUARD_HALF = 13'h1000;
  localparam logic [12:0] GUARD_ALL = 13'h0000;
  // Write cycle time
  localparam int WRITE_MS = 5;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_CYCLES = WRITE_MS * 1000 * CLK_MHZ;
  // Reset values of nonvolatile bits
  localparam logic [2:0] NV_RESET = 3'h0;
endpackage

// [hw/eswp_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for one level
module eswp_sync (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta_q <= 1'b0;
      q_out <= 1'b0;
    end
    else
    begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// [hw/eswp_top.sv]
`timescale 1ns/1ps
// Function
// R1: Status read answers at any time, even while busy.
// R2: Status layout: 7 pin enable, 3/2 guard bits, 1 latch, 0 busy.
// R3: Busy flag shows internal write, never written by status write.
// R4: Latch flag mirrors latch; writes refused when clear; read-only.
// R5: Latch set and clear commands always act, regardless of protection.
// R6: Guard bits written only by status write, kept nonvolatile.
// R7: Guard 00 none, 01 1800h up, 10 1000h up, 11 all.
// R8: Pin enable bit gates whether the lock pin protects.
// R9: Hardware protection only when lock pin low and enable set.
// R10: Hardware protection blocks only nonvolatile status writes.
// R11: Latch cleared at power-up.
// R12: Host sets latch before each write; writes refused if clear.
// R13: Latch cleared after byte, page or status write.
// R14: Internal write starts only on correctly timed select rise.
// R15: Array accesses during a write cycle are ignored.
// R16: Power-on standby, latch clear, data output high impedance.
// R17: Leave standby only after a select falling edge.
// R18: Latch 0 nothing writable; guards hold; status per pin protection.
// R19: Command codes 06 set, 04 clear, 05 read, 01 write.
// R20: MSB first; sample on rising clock, drive after falling.
// R21: A started write cycle completes despite the lock pin.
// R22: Status read shifts status out; status write takes one byte.
// R23: Busy set on valid start, cleared at end with latch.
module eswp_top
  import eswp_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic sck_in,
  input wire logic sel_n_in,
  input wire logic sdi_in,
  input wire logic write_lock_n_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic [7:0] status_out
);
  import eswp_pkg::*;

  // Link-domain registers (serial clock)
  logic [5:0] bit_cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] shin_q;
  logic [12:0] addr_q;
  logic [7:0] stat_wr_q;
  logic [7:0] sh_out_q;
  logic tx_on_q;
  logic sdo_q;
  logic oe_q;
  logic [7:0] stat_meta_q;
  logic [7:0] stat_lk_q;
  logic [7:0] cmd_d;
  logic [7:0] shin_d;
  // Core-domain registers, except the event toggles clocked on select rise
  logic latch_q;
  logic busy_q;
  logic pin_en_q;
  logic guard_hi_q;
  logic guard_lo_q;
  logic [31:0] wcnt_q;
  logic [7:0] status_q;
  logic sel_s;
  logic lock_s;
  logic sel_d1_q;
  logic ev_set_tg_q;
  logic ev_clr_tg_q;
  logic ev_stw_tg_q;
  logic ev_arw_tg_q;
  logic ev_set_s;
  logic ev_clr_s;
  logic ev_stw_s;
  logic ev_arw_s;
  logic [3:0] ev_d1_q;
  logic [7:0] stw_core_q;
  logic [12:0] addr_core_q;

  // Serial decode wires
  wire [7:0] sh_next = {shin_q[6:0], sdi_in};
  wire [5:0] cnt_next = bit_cnt_q + 6'h01;
  wire is_set = (cmd_q == CMD_LATCH_SET) && (bit_cnt_q == CNT_BYTE);
  wire is_clr = (cmd_q == CMD_LATCH_CLR) && (bit_cnt_q == CNT_BYTE);
  wire is_stw = (cmd_q == CMD_STAT_WR) && (bit_cnt_q == CNT_STAT_WR);
  // Array write ends on a byte boundary after at least one data byte [R14]
  wire is_arw = (cmd_q == CMD_ARR_WR) && (bit_cnt_q > CNT_ARR_HDR)
                && (bit_cnt_q[2:0] == 3'h0);
  // Status image presented to the link [R1] [R2] [R3]
  wire [7:0] stat_img = {stat_lk_q[BIT_PIN_EN], 3'h0, stat_lk_q[BIT_GUARD_HI:BIT_BUSY]};

  // Shift in MSB first on rising edge; reset while deselected [R20] [R17]
  always_ff @(posedge sck_in or posedge sel_n_in)
  begin
    if (sel_n_in)
    begin
      bit_cnt_q <= 6'h00;
      cmd_q <= 8'h00;
      shin_q <= 8'h00;
    end
    else
    begin
      bit_cnt_q <= (bit_cnt_q == 6'h3f) ? CNT_ARR_HDR : cnt_next;
      shin_q <= shin_d;
      cmd_q <= cmd_d;
    end
  end

  // Command capture after the eighth bit [R19]
  always_comb
  begin
    shin_d = sh_next;
    cmd_d = cmd_q;
    if (bit_cnt_q == (CNT_BYTE - 6'h01))
      cmd_d = sh_next;
  end

  // Status write data and array address; kept past frame end for the core [R22]
  always_ff @(posedge sck_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stat_wr_q <= 8'h00;
      addr_q <= 13'h0000;
    end
    else
    begin
      if (!sel_n_in && cmd_q == CMD_STAT_WR && bit_cnt_q == (CNT_STAT_WR - 6'h01))
        stat_wr_q <= sh_next;
      if (!sel_n_in && bit_cnt_q >= CNT_BYTE && bit_cnt_q < CNT_ARR_HDR)
        addr_q <= {addr_q[11:0], sdi_in};
    end
  end

  // Two-stage status snapshot into the link domain on falling edges
  always_ff @(negedge sck_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stat_meta_q <= 8'h00;
      stat_lk_q <= 8'h00;
    end
    else
    begin
      stat_meta_q <= status_q;
      stat_lk_q <= stat_meta_q;
    end
  end

  // Output shifter updates after falling edge; off when deselected or in reset [R20] [R16]
  always_ff @(negedge sck_in or posedge sel_n_in or negedge nrst_in)
  begin
    if (sel_n_in || !nrst_in)
    begin
      sh_out_q <= 8'h00;
      tx_on_q <= 1'b0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (cmd_q == CMD_STAT_RD && bit_cnt_q[2:0] == 3'h0 && bit_cnt_q >= CNT_BYTE)
    begin
      sdo_q <= stat_img[7];
      sh_out_q <= {stat_img[6:0], 1'b0};
      tx_on_q <= 1'b1;
      oe_q <= 1'b1;
    end
    else if (tx_on_q)
    begin
      sdo_q <= sh_out_q[7];
      sh_out_q <= {sh_out_q[6:0], 1'b0};
    end
  end

  // Frame-end events as toggles, sampled on select rise [R14]
  always_ff @(posedge sel_n_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ev_set_tg_q <= 1'b0;
      ev_clr_tg_q <= 1'b0;
      ev_stw_tg_q <= 1'b0;
      ev_arw_tg_q <= 1'b0;
    end
    else
    begin
      ev_set_tg_q <= ev_set_tg_q ^ is_set;
      ev_clr_tg_q <= ev_clr_tg_q ^ is_clr;
      ev_stw_tg_q <= ev_stw_tg_q ^ is_stw;
      ev_arw_tg_q <= ev_arw_tg_q ^ is_arw;
    end
  end

  // Pin and event-toggle synchronisers into the core clock
  eswp_sync u_sync_sel (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(sel_n_in), .q_out(sel_s));
  eswp_sync u_sync_lock (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(write_lock_n_in),
    .q_out(lock_s));
  eswp_sync u_sync_e0 (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(ev_set_tg_q),
    .q_out(ev_set_s));
  eswp_sync u_sync_e1 (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(ev_clr_tg_q),
    .q_out(ev_clr_s));
  eswp_sync u_sync_e2 (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(ev_stw_tg_q),
    .q_out(ev_stw_s));
  eswp_sync u_sync_e3 (.clock_in(clock_in), .nrst_in(nrst_in), .d_in(ev_arw_tg_q),
    .q_out(ev_arw_s));

  // Event pulses in the core domain
  wire set_p = ev_set_s ^ ev_d1_q[0];
  wire clr_p = ev_clr_s ^ ev_d1_q[1];
  wire stw_p = ev_stw_s ^ ev_d1_q[2];
  wire arw_p = ev_arw_s ^ ev_d1_q[3];
  // Hardware protection [R8] [R9]
  wire hw_prot = pin_en_q && !lock_s;
  // Guarded region lookup [R7]
  wire [12:0] guard_base = guard_hi_q ? (guard_lo_q ? GUARD_ALL : GUARD_HALF) : GUARD_QTR;
  wire guard_hit = (guard_hi_q || guard_lo_q) && (addr_core_q >= guard_base);
  // Write permission [R18] [R12] [R15] [R10]
  wire stw_ok = stw_p && latch_q && !hw_prot && !busy_q;
  wire arw_ok = arw_p && latch_q && !guard_hit && !busy_q;
  wire wr_done = busy_q && (wcnt_q == 32'(WRITE_CYCLES_P - 1));

  // Words sampled every cycle; settled long before the frame-end event lands
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stw_core_q <= 8'h00;
      addr_core_q <= 13'h0000;
      ev_d1_q <= 4'h0;
      sel_d1_q <= 1'b1;
    end
    else
    begin
      ev_d1_q <= {ev_arw_s, ev_stw_s, ev_clr_s, ev_set_s};
      sel_d1_q <= sel_s;
      stw_core_q <= stat_wr_q;
      addr_core_q <= addr_q;
    end
  end

  // Latch control: commands always act; cleared after writes [R5] [R11] [R13] [R23]
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      latch_q <= 1'b0;
    else if (set_p)
      latch_q <= 1'b1;
    else if (clr_p || wr_done)
      latch_q <= 1'b0;
  end

  // Busy and write timer; completes regardless of lock pin [R3] [R21] [R23]
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      busy_q <= 1'b0;
      wcnt_q <= 32'h0;
    end
    else if (stw_ok || arw_ok)
    begin
      busy_q <= 1'b1;
      wcnt_q <= 32'h0;
    end
    else if (wr_done)
      busy_q <= 1'b0;
    else if (busy_q)
      wcnt_q <= wcnt_q + 32'h1;
  end

  // Nonvolatile bits, written only by an accepted status write [R6] [R8]
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      {pin_en_q, guard_hi_q, guard_lo_q} <= NV_RESET;
    else if (stw_ok)
      {pin_en_q, guard_hi_q, guard_lo_q} <= {stw_core_q[BIT_PIN_EN],
        stw_core_q[BIT_GUARD_HI], stw_core_q[BIT_GUARD_LO]};
  end

  // Status register image [R2] [R4]
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      status_q <= 8'h00;
    else
      status_q <= {pin_en_q, 3'h0, guard_hi_q, guard_lo_q, latch_q, busy_q};
  end

  assign sdo_out = sdo_q;
  assign sdo_oe_out = oe_q;
  assign status_out = status_q;

  // Assertions
  sequence s_busy_start;
    (stw_ok || arw_ok) ##1 busy_q;
  endsequence
  a_busy_on_start: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (stw_ok || arw_ok) |-> s_busy_start) else $error("busy not set on start"); // [R23]
  a_latch_end_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (wr_done && !set_p) |=> !latch_q) else $error("latch not cleared"); // [R13]
  a_latch_set_cmd: assert property (@(posedge clock_in) disable iff (!nrst_in)
    set_p |=> latch_q) else $error("latch set ignored"); // [R5]
  a_latch_clr_cmd: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (clr_p && !set_p) |=> !latch_q) else $error("latch clear ignored"); // [R5]
  a_no_write_unlatched: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (!latch_q && !busy_q) |=> !busy_q) else $error("write without latch"); // [R12]
  a_hw_prot_status: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (stw_p && hw_prot) |=> $stable({pin_en_q, guard_hi_q, guard_lo_q}))
    else $error("status written under protection"); // [R10]
  a_guard_blocks: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (arw_p && guard_hi_q && guard_lo_q) |-> !arw_ok) else $error("guarded write"); // [R7]
  a_status_image: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> status_q == {$past(pin_en_q), 3'h0, $past(guard_hi_q), $past(guard_lo_q),
    $past(latch_q), $past(busy_q)}) else $error("status layout wrong"); // [R2]
  a_busy_held: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (busy_q && !wr_done) |=> busy_q) else $error("write cut short"); // [R21]
  a_sdo_off_idle: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (sel_s && sel_d1_q) |-> !oe_q) else $error("sdo driven while idle"); // [R16]
endmodule

// [tb/eswp_spi_master.sv]
`timescale 1ns/1ps
// Host side of the serial link; its clock runs only inside frames
module eswp_spi_master (
  output logic sck_out,
  output logic sel_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  // Idle: deselected, clock low
  initial
  begin
    sck_out = 1'b0;
    sel_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // One frame of n bits taken from the top of bits; byte after command returned
  task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #3 sel_n_out = 1'b0;
    #80;
    for (int i = 0; i < n; i++)
    begin
      sdi_out = bits[31 - i];
      #80 sck_out = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], sdo_in};
      #80 sck_out = 1'b0;
    end
    #80 sel_n_out = 1'b1;
    sdi_out = ~sdi_out; // Released line shows no stale bit
    #1000;
  endtask
endmodule

// [tb/eswp_top_tb.sv]
`timescale 1ns/1ps
module eswp_top_tb;
  import eswp_pkg::*;
  localparam int WCYC = 600;
  logic clock_in, nrst_in, write_lock_n_in, sck, sel_n, sdi, sdo, sdo_oe;
  logic [7:0] status, rd;
  logic pe, lat, busy, lock_n;
  logic [1:0] grd;
  logic [12:0] addr;
  // Undriven data line reads high, the inverse of sdo, which is cleared while undriven
  wire sdo_line = sdo_oe ? sdo : ~sdo;
  int mismatches, n_checks, seed, op;

  eswp_top #(.WRITE_CYCLES_P(WCYC)) u_eswp_top (.clock_in(clock_in), .nrst_in(nrst_in),
    .sck_in(sck), .sel_n_in(sel_n), .sdi_in(sdi), .write_lock_n_in(write_lock_n_in),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .status_out(status));
  eswp_spi_master u_eswp_spi_master (.sck_out(sck), .sel_n_out(sel_n), .sdi_out(sdi),
    .sdo_in(sdo_line));

  // Core clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // Expected status image from the bench model
  function automatic logic [7:0] exp_stat();
    return {pe, 3'h0, grd, lat, busy};
  endfunction

  // Array address falls in a guarded block
  function automatic logic guarded(input logic [1:0] g, input logic [12:0] a);
    return (g == 2'h3) || (g == 2'h2 && a >= GUARD_HALF) || (g == 2'h1 && a >= GUARD_QTR);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    n_checks++;
    if ((got & m) !== (exp & m))
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the write cycle to end
  task automatic wait_idle();
    int k;
    k = 0;
    while (status[BIT_BUSY] !== 1'b0 && k < 3000)
    begin
      @(negedge clock_in);
      k++;
    end
    if (k == 3000)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t busy stuck", $time);
      tally_and_finish();
    end
  endtask

  task automatic set_lock(input logic v);
    @(negedge clock_in);
    write_lock_n_in = v;
    lock_n = v;
    repeat (5) @(negedge clock_in);
  endtask

  // 0 set, 1 clear, 2 status write, 3 short status write, 4 array write, 5 read
  task automatic do_op(input int op, input logic [7:0] v);
    if (op < 2)
    begin
      u_eswp_spi_master.frame({(op == 0) ? CMD_LATCH_SET : CMD_LATCH_CLR, 24'h0}, 8, rd);
      lat = (op == 0);
    end
    else if (op < 4)
    begin
      u_eswp_spi_master.frame({CMD_STAT_WR, v, 16'h0}, 18 - op, rd);
      if (op == 2 && lat && !(pe && !lock_n))
      begin
        pe = v[BIT_PIN_EN];
        grd = v[3:2];
        lat = 1'b0;
      end
    end
    else if (op == 4)
    begin
      addr = 13'($random(seed));
      u_eswp_spi_master.frame({CMD_ARR_WR, 3'h0, addr, v}, 32, rd);
      if (lat && !guarded(grd, addr))
      begin
        busy = 1'b1;
        chk(status, exp_stat(), 8'hff);
        u_eswp_spi_master.frame({CMD_STAT_RD, 24'h0}, 16, rd);
        chk(rd, exp_stat(), 8'h8f);
        busy = 1'b0;
        lat = 1'b0;
      end
    end
    else
    begin
      u_eswp_spi_master.frame({CMD_STAT_RD, 24'h0}, 16, rd);
      chk(rd, exp_stat(), 8'h8f);
    end
    wait_idle();
    chk(status, exp_stat(), 8'hff);
    chk({7'h0, sdo_oe}, 8'h00, 8'hff);
  endtask

  // Main sequence: corners first, then random traffic
  initial
  begin
    seed = 32'h7cf8;
    mismatches = 0;
    n_checks = 0;
    nrst_in = 1'b1;
    write_lock_n_in = 1'b1;
    {pe, grd, lat, busy, lock_n} = 6'h01;
    // Reset falls on a clean edge so every async flop sees it
    @(negedge clock_in);
    nrst_in = 1'b0;
    repeat (10) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (10) @(negedge clock_in);
    chk(status, 8'h00, 8'hff);
    chk({7'h0, sdo_oe}, 8'h00, 8'hff);
    do_op(2, 8'h8c);
    do_op(0, 8'h00);
    do_op(2, 8'h88);
    set_lock(1'b0);
    do_op(0, 8'h00);
    do_op(2, 8'h00);
    do_op(5, 8'h00);
    do_op(1, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      set_lock(1'($random(seed)));
      do_op(int'($random(seed) & 1), 8'h00);
      op = 2 + int'(($random(seed) & 32'h7fff) % 4);
      do_op(op, 8'($random(seed)));
    end
    tally_and_finish();
  end
endmodule
